//--- verilog/csb_core.sv
`timescale 1ns/100ps
`include "csb_regs.svh"

// Overview of operation
// - arithmetic flag writes replaced by operation result
// - expiry and sleep flags never software writable
// - clearing flag register zeroes pages, sets zero
// - indirect page bit picks banks two/three
// - two direct page bits pick one bank
// - expiry flag set by power-up, kick, sleep
// - sleep flag set by power-up, kick; sleep clears
// - zero flag follows zero result
// - nibble carry from bit three on add/sub
// - carry from bit seven on add/sub
// - subtract adds two's complement; carry means no-borrow
// - rotates load carry with shifted-out bit
// - core registers visible in every bank
// - high latch copied to upper counter on load
// - scaler owned by one user; timer undivided otherwise
// - watchdog has its own divide counter
// - owner bit set gives scaler to watchdog
// - ratio field divides timer 2..256, watchdog 1..128
module csb_core
(
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                reset_n,
   // instruction from the datapath
   input  wire logic                instr_valid,
   input  wire csb_pkg::csb_op_t    instr_op,
   input  wire logic                instr_sleep,
   input  wire logic [7:0]          work_val,
   input  wire logic [7:0]          src_val,
   input  wire logic [6:0]          file_field,
   input  wire logic [2:0]          bit_sel,
   input  wire logic                dest_is_file,
   // instruction results
   output logic [7:0]               result_r,
   output logic                     work_wr_r,
   output logic                     ext_wr_r,
   output logic [8:0]               data_addr_r,
   // read port
   input  wire logic                rd_req,
   input  wire logic [6:0]          rd_field,
   output logic [7:0]               rd_data_r,
   output logic                     rd_local_r,
   output logic [8:0]               rd_addr_r,
   // program counter
   input  wire logic                pc_step,
   input  wire logic                pc_load,
   input  wire logic [7:0]          pc_load_low,
   output logic [12:0]              pc_r,
   // scaler, timer and watchdog
   input  wire logic                wdog_enable,
   input  wire logic [3:0]          wdog_period_sel,
   input  wire logic                timer_src_pulse,
   output logic                     timer_tick_r,
   output logic                     wdog_timeout_r,
   output logic [7:0]               status_out_r,
   output logic [7:0]               option_out_r
);

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [6:0] lo7(input logic [8:0] a);
      return a[6:0];
   endfunction

   // {carry, nibble carry, sum}; subtract adds the inverted operand plus one
   function automatic logic [9:0] arith(input logic [7:0] a, input logic [7:0] b,
                                        input logic sub);
      logic [7:0] bb;
      logic [4:0] lo;
      logic [8:0] full;
      bb   = sub ? ~b : b;
      lo   = {1'h0, a[3:0]} + {1'h0, bb[3:0]} + {4'h0, sub};
      full = {1'h0, a} + {1'h0, bb} + {8'h00, sub};
      return {full[8], lo[4], full[7:0]};
   endfunction

   // registers that appear at the same low address in every bank
   function automatic logic is_shared(input logic [6:0] f);
      return f == lo7(`CSB_ADDR_INDIRECT_WINDOW) || f == lo7(`CSB_ADDR_PROG_COUNTER_LOW)
          || f == lo7(`CSB_ADDR_ARITH_FLAGS) || f == lo7(`CSB_ADDR_INDIRECT_POINTER)
          || f == lo7(`CSB_ADDR_PC_HIGH_LATCH) || f == lo7(`CSB_ADDR_INTERRUPT_CONTROL);
   endfunction

   // last count of the shared scaler for the present owner
   function automatic logic [7:0] scaler_last(input logic owner, input logic [2:0] ps);
      return owner ? (8'h01 << ps) - 8'h01 : (8'h02 << ps) - 8'h01;
   endfunction

   // resolve a 7-bit field to a data address, window redirected through the pointer
   function automatic logic [8:0] target(input logic [6:0] f, input logic [7:0] st,
                                         input logic [7:0] ptr);
      if (f == lo7(`CSB_ADDR_INDIRECT_WINDOW))
         return {st[`CSB_ST_INDIRECT_PAGE], ptr};
      return {st[`CSB_ST_PAGE_HI], st[`CSB_ST_PAGE_LO], f};
   endfunction

   // shared registers fold to their bank 0 image so the outside sees one copy
   function automatic logic [8:0] fold(input logic [8:0] a);
      return is_shared(a[6:0]) ? {2'h0, a[6:0]} : a;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // state

   logic [7:0]               status_r;
   logic [7:0]               status_nxt;
   logic [7:0]               option_r;
   logic [7:0]               pointer_r;
   logic [`CSB_PROG_COUNTER_HIGH_LATCH_W-1:0] prog_counter_high_latch_r;
   logic [31:0]              wdog_div_r;
   logic [7:0]               scaler_r;

   logic [7:0] res;
   logic       res_c;
   logic       res_dc;
   logic       aff_z;
   logic       aff_dc;
   logic       aff_c;
   logic       writes_file;
   logic [8:0] wr_tgt;
   logic       wr_en;
   logic       wr_local;
   logic [8:0] rd_tgt;
   logic       base_tick;
   logic       scaler_wrap;
   logic       wdog_expire;
   logic       owner_wdog;
   logic       is_kick;
   logic       is_sleep;

   assign owner_wdog = option_r[`CSB_OPT_SCALER_OWNER];
   assign is_kick    = instr_valid && instr_op == csb_pkg::CSB_OP_KICK;
   assign is_sleep   = instr_valid && instr_sleep;

   ////////////////////////////////////////////////////////////////////////////////
   // operation result and flag selection

   always_comb
   begin
      logic [9:0] ar;
      ar          = arith(src_val, work_val, 1'h0);
      res         = 8'h00;
      res_c       = status_r[`CSB_ST_CARRY];
      res_dc      = status_r[`CSB_ST_NIBBLE_CARRY];
      aff_z       = 1'h0;
      aff_dc      = 1'h0;
      aff_c       = 1'h0;
      writes_file = dest_is_file;
      unique case (instr_op)
         csb_pkg::CSB_OP_ADD_FILE, csb_pkg::CSB_OP_ADD_LIT:
         begin
            {res_c, res_dc, res} = ar;
            {aff_z, aff_dc, aff_c} = 3'h7;
         end
         csb_pkg::CSB_OP_SUB_FILE, csb_pkg::CSB_OP_SUB_LIT:
         begin
            ar = arith(src_val, work_val, 1'h1);
            {res_c, res_dc, res} = ar;
            {aff_z, aff_dc, aff_c} = 3'h7;
         end
         csb_pkg::CSB_OP_ROT_LEFT:
         begin
            res   = {src_val[6:0], status_r[`CSB_ST_CARRY]};
            res_c = src_val[7];
            aff_c = 1'h1;
         end
         csb_pkg::CSB_OP_ROT_RIGHT:
         begin
            res   = {status_r[`CSB_ST_CARRY], src_val[7:1]};
            res_c = src_val[0];
            aff_c = 1'h1;
         end
         csb_pkg::CSB_OP_AND:
         begin
            res   = src_val & work_val;
            aff_z = 1'h1;
         end
         csb_pkg::CSB_OP_OR:
         begin
            res   = src_val | work_val;
            aff_z = 1'h1;
         end
         csb_pkg::CSB_OP_XOR:
         begin
            res   = src_val ^ work_val;
            aff_z = 1'h1;
         end
         csb_pkg::CSB_OP_CLEAR:
         begin
            // both carries reload their own value, so a cleared flag register keeps them
            {aff_z, aff_dc, aff_c} = 3'h7;
            writes_file = 1'h1;
         end
         csb_pkg::CSB_OP_MOVE:
         begin
            res         = work_val;
            writes_file = 1'h1;
         end
         csb_pkg::CSB_OP_BIT_SET:
         begin
            res         = src_val | (8'h01 << bit_sel);
            writes_file = 1'h1;
         end
         csb_pkg::CSB_OP_BIT_CLEAR:
         begin
            res         = src_val & ~(8'h01 << bit_sel);
            writes_file = 1'h1;
         end
         csb_pkg::CSB_OP_SWAP:
            res = {src_val[3:0], src_val[7:4]};
         csb_pkg::CSB_OP_NONE, csb_pkg::CSB_OP_KICK:
            writes_file = 1'h0;
      endcase
   end

   assign wr_tgt   = target(file_field, status_r, pointer_r);
   assign wr_en    = instr_valid && writes_file && !is_sleep;
   assign wr_local = is_shared(wr_tgt[6:0]) && wr_tgt[6:0] != lo7(`CSB_ADDR_INTERRUPT_CONTROL)
                     || wr_tgt == `CSB_ADDR_TIMER_OPTION
                     || wr_tgt == `CSB_ADDR_RESERVED_A || wr_tgt == `CSB_ADDR_RESERVED_B;

   ////////////////////////////////////////////////////////////////////////////////
   // flag register

   always_comb
   begin
      status_nxt = status_r;
      if (wr_en && wr_tgt[6:0] == lo7(`CSB_ADDR_ARITH_FLAGS))
      begin
         // expiry and sleep bits are left out of the write on purpose
         status_nxt[7:5] = res[7:5];
         if (!aff_z)
            status_nxt[`CSB_ST_ZERO] = res[`CSB_ST_ZERO];
         if (!aff_dc)
            status_nxt[`CSB_ST_NIBBLE_CARRY] = res[`CSB_ST_NIBBLE_CARRY];
         if (!aff_c)
            status_nxt[`CSB_ST_CARRY] = res[`CSB_ST_CARRY];
      end
      if (instr_valid && aff_z)
         status_nxt[`CSB_ST_ZERO] = res == 8'h00;
      if (instr_valid && aff_dc)
         status_nxt[`CSB_ST_NIBBLE_CARRY] = res_dc;
      if (instr_valid && aff_c)
         status_nxt[`CSB_ST_CARRY] = res_c;
      // timeout clears first so a kick or sleep in the same cycle wins
      if (wdog_expire)
         status_nxt[`CSB_ST_WDOG_EXPIRY] = 1'h0;
      if (is_kick)
      begin
         status_nxt[`CSB_ST_WDOG_EXPIRY] = 1'h1;
         status_nxt[`CSB_ST_SLEEP_ENTRY] = 1'h1;
      end
      if (is_sleep)
      begin
         status_nxt[`CSB_ST_WDOG_EXPIRY] = 1'h1;
         status_nxt[`CSB_ST_SLEEP_ENTRY] = 1'h0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         status_r <= `CSB_STATUS_RST;
      else
         status_r <= status_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pointer, option, high latch and program counter

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         pointer_r <= `CSB_POINTER_RST;
         option_r  <= `CSB_OPTION_RST;
         prog_counter_high_latch_r  <= `CSB_PROG_COUNTER_HIGH_LATCH_RST;
      end
      else if (wr_en)
      begin
         if (wr_tgt[6:0] == lo7(`CSB_ADDR_INDIRECT_POINTER))
            pointer_r <= res;
         if (wr_tgt[6:0] == lo7(`CSB_ADDR_PC_HIGH_LATCH))
            prog_counter_high_latch_r <= res[`CSB_PROG_COUNTER_HIGH_LATCH_W-1:0];
         if (wr_tgt == `CSB_ADDR_TIMER_OPTION)
            option_r <= res;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         pc_r <= {`CSB_PROG_COUNTER_HIGH_LATCH_RST, `CSB_PCL_RST};
      else if (wr_en && wr_tgt[6:0] == lo7(`CSB_ADDR_PROG_COUNTER_LOW))
         pc_r <= {prog_counter_high_latch_r, res};
      else if (pc_load)
         pc_r <= {prog_counter_high_latch_r, pc_load_low};
      else if (pc_step)
         pc_r <= pc_r + 13'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // instruction outputs and read port

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         result_r    <= 8'h00;
         work_wr_r   <= 1'h0;
         ext_wr_r    <= 1'h0;
         data_addr_r <= 9'h000;
      end
      else
      begin
         result_r    <= res;
         work_wr_r   <= instr_valid && !writes_file && instr_op != csb_pkg::CSB_OP_NONE
                        && !is_kick && !is_sleep;
         ext_wr_r    <= wr_en && !wr_local;
         data_addr_r <= fold(wr_tgt);
      end
   end

   assign rd_tgt = target(rd_field, status_r, pointer_r);

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         rd_data_r  <= 8'h00;
         rd_local_r <= 1'h0;
         rd_addr_r  <= 9'h000;
      end
      else if (rd_req)
      begin
         rd_addr_r  <= fold(rd_tgt);
         rd_local_r <= 1'h1;
         // the window read through itself has no storage and returns zero
         if (rd_tgt[6:0] == lo7(`CSB_ADDR_PROG_COUNTER_LOW))
            rd_data_r <= pc_r[7:0];
         else if (rd_tgt[6:0] == lo7(`CSB_ADDR_ARITH_FLAGS))
            rd_data_r <= status_r;
         else if (rd_tgt[6:0] == lo7(`CSB_ADDR_INDIRECT_POINTER))
            rd_data_r <= pointer_r;
         else if (rd_tgt[6:0] == lo7(`CSB_ADDR_PC_HIGH_LATCH))
            rd_data_r <= {3'h0, prog_counter_high_latch_r};
         else if (rd_tgt == `CSB_ADDR_TIMER_OPTION)
            rd_data_r <= option_r;
         else
         begin
            rd_data_r  <= 8'h00;
            rd_local_r <= rd_tgt[6:0] == lo7(`CSB_ADDR_INDIRECT_WINDOW)
                          || rd_tgt == `CSB_ADDR_RESERVED_A || rd_tgt == `CSB_ADDR_RESERVED_B;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         status_out_r <= `CSB_STATUS_RST;
         option_out_r <= `CSB_OPTION_RST;
      end
      else
      begin
         status_out_r <= status_nxt;
         option_out_r <= option_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog divider and shared scaler

   // own divider ahead of the scaler, so the watchdog keeps a period with no scaler
   assign base_tick   = wdog_enable
                        && wdog_div_r == (`CSB_WDOG_BASE_CYCLES << wdog_period_sel) - 32'h1;
   // a count left above a newly chosen smaller ratio wraps at once instead of running to 255
   assign scaler_wrap = scaler_r >= scaler_last(owner_wdog, option_r[`CSB_OPT_RATIO_HI:0]);
   assign wdog_expire = base_tick && (!owner_wdog || scaler_wrap);

   always_ff @(posedge core_clk)
   begin
      if (!reset_n || !wdog_enable || is_kick || is_sleep || base_tick)
         wdog_div_r <= 32'h0;
      else
         wdog_div_r <= wdog_div_r + 32'h1;
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n || (owner_wdog && (is_kick || is_sleep)))
         scaler_r <= 8'h00;
      else if (owner_wdog ? base_tick : timer_src_pulse)
         scaler_r <= scaler_wrap ? 8'h00 : scaler_r + 8'h01;
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         timer_tick_r   <= 1'h0;
         wdog_timeout_r <= 1'h0;
      end
      else
      begin
         timer_tick_r   <= timer_src_pulse && (owner_wdog || scaler_wrap);
         wdog_timeout_r <= wdog_expire;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   flag_result_a: assert property (instr_valid && aff_z && !wdog_expire |=>
      status_r[`CSB_ST_ZERO] == ($past(res) == 8'h00))
      else $error("zero flag does not follow result");
   status_arith_a: assert property (wr_en && wr_tgt[6:0] == 7'h03 && aff_c |=>
      status_r[`CSB_ST_CARRY] == $past(res_c))
      else $error("carry taken from written data");
   ro_flags_a: assert property (wr_en && instr_op == csb_pkg::CSB_OP_MOVE && !wdog_expire
      |=> status_r[4:3] == $past(status_r[4:3]))
      else $error("read-only flags changed by write");
   clear_status_a: assert property (wr_en && instr_op == csb_pkg::CSB_OP_CLEAR
      && wr_tgt[6:0] == 7'h03 && !wdog_expire
      |=> status_r == {3'h0, $past(status_r[4:3]), 1'h1, $past(status_r[1:0])})
      else $error("clearing flag register wrong");
   indirect_page_a: assert property (wr_en && file_field == 7'h00 && !is_shared(pointer_r[6:0])
      |=> data_addr_r == {$past(status_r[7]), $past(pointer_r)})
      else $error("indirect address wrong");
   direct_page_a: assert property (wr_en && file_field != 7'h00 && !is_shared(file_field)
      |=> data_addr_r == {$past(status_r[6:5]), $past(file_field)})
      else $error("direct address wrong");
   shared_map_a: assert property (wr_en && file_field == 7'h0b
      |=> data_addr_r == 9'h00b && ext_wr_r)
      else $error("shared register not folded");
   kick_flags_a: assert property (is_kick && !is_sleep |=> status_r[4:3] == 2'h3)
      else $error("kick did not set flags");
   sleep_flags_a: assert property (is_sleep && !is_kick |=> status_r[4:3] == 2'h2)
      else $error("sleep flags wrong");
   timeout_flag_a: assert property (wdog_expire && !is_kick && !is_sleep
      |=> !status_r[`CSB_ST_WDOG_EXPIRY] && wdog_timeout_r)
      else $error("timeout did not clear expiry flag");
   sub_carry_a: assert property (instr_valid && instr_op == csb_pkg::CSB_OP_SUB_FILE
      |-> res_c == (src_val >= work_val) && res == src_val - work_val)
      else $error("subtract borrow wrong");
   rot_carry_a: assert property (instr_valid && instr_op == csb_pkg::CSB_OP_ROT_LEFT
      |=> status_r[`CSB_ST_CARRY] == $past(src_val[7]))
      else $error("rotate carry wrong");
   pc_latch_a: assert property (pc_load && !wr_en |=> pc_r == {$past(prog_counter_high_latch_r), $past(pc_load_low)})
      else $error("high latch not transferred");
   timer_undiv_a: assert property (owner_wdog |=> timer_tick_r == $past(timer_src_pulse))
      else $error("timer divided while scaler on watchdog");
   scaler_ratio_a: assert property (!owner_wdog && option_r[2:0] == 3'h0
      && timer_src_pulse ##1 timer_src_pulse && $stable(option_r) |=> timer_tick_r != $past(timer_tick_r))
      else $error("timer ratio two wrong");

   add_status_c: cover property (wr_en && wr_tgt[6:0] == 7'h03 && instr_op == csb_pkg::CSB_OP_ADD_FILE);
   timeout_c:    cover property (wdog_timeout_r);
   indirect_c:   cover property (wr_en && file_field == 7'h00 && status_r[7]);
   pcl_write_c:  cover property (wr_en && wr_tgt[6:0] == 7'h02);

endmodule

//--- verilog/csb_regs.svh
`ifndef CSB_REGS_SVH
`define CSB_REGS_SVH

// register offsets, bank 2 and bank 3 view; shared registers decode on the low seven bits
`define CSB_ADDR_NV_DATA_LOW       9'h10c
`define CSB_ADDR_NV_ADDRESS_LOW    9'h10d
`define CSB_ADDR_NV_DATA_HIGH      9'h10e
`define CSB_ADDR_NV_ADDRESS_HIGH   9'h10f
`define CSB_ADDR_INDIRECT_WINDOW   9'h180
`define CSB_ADDR_TIMER_OPTION      9'h181
`define CSB_ADDR_PROG_COUNTER_LOW  9'h182
`define CSB_ADDR_ARITH_FLAGS       9'h183
`define CSB_ADDR_INDIRECT_POINTER  9'h184
`define CSB_ADDR_PORT_B_DIRECTION  9'h186
`define CSB_ADDR_PC_HIGH_LATCH     9'h18a
`define CSB_ADDR_INTERRUPT_CONTROL 9'h18b
`define CSB_ADDR_NV_CONTROL_ONE    9'h18c
`define CSB_ADDR_NV_CONTROL_UNLOCK 9'h18d
`define CSB_ADDR_RESERVED_A        9'h18e
`define CSB_ADDR_RESERVED_B        9'h18f

// arith_flags_and_page fields
`define CSB_ST_INDIRECT_PAGE 7
`define CSB_ST_PAGE_HI       6
`define CSB_ST_PAGE_LO       5
`define CSB_ST_WDOG_EXPIRY   4
`define CSB_ST_SLEEP_ENTRY   3
`define CSB_ST_ZERO          2
`define CSB_ST_NIBBLE_CARRY  1
`define CSB_ST_CARRY         0

// timer_option_control fields
`define CSB_OPT_SCALER_OWNER 3
`define CSB_OPT_RATIO_HI     2

// reset values
`define CSB_STATUS_RST   8'h18
`define CSB_OPTION_RST   8'hff
`define CSB_PCL_RST      8'h00
`define CSB_PROG_COUNTER_HIGH_LATCH_RST   5'h00
`define CSB_POINTER_RST  8'h00

// program counter high latch width
`define CSB_PROG_COUNTER_HIGH_LATCH_W     5

// watchdog base divide, in core clock cycles, before the period select shift
`define CSB_WDOG_BASE_CYCLES 32'h0000_4000

`endif

//--- verilog/csb_pkg.sv
package csb_pkg;

   // operation presented by the instruction datapath for one instruction cycle
   typedef enum logic [3:0]
   {
      CSB_OP_NONE      = 4'h0,
      CSB_OP_ADD_FILE  = 4'h1,
      CSB_OP_ADD_LIT   = 4'h2,
      CSB_OP_SUB_FILE  = 4'h3,
      CSB_OP_SUB_LIT   = 4'h4,
      CSB_OP_ROT_LEFT  = 4'h5,
      CSB_OP_ROT_RIGHT = 4'h6,
      CSB_OP_AND       = 4'h7,
      CSB_OP_OR        = 4'h8,
      CSB_OP_XOR       = 4'h9,
      CSB_OP_CLEAR     = 4'ha,
      CSB_OP_MOVE      = 4'hb,
      CSB_OP_BIT_SET   = 4'hc,
      CSB_OP_BIT_CLEAR = 4'hd,
      CSB_OP_SWAP      = 4'he,
      CSB_OP_KICK      = 4'hf
   } csb_op_t;

endpackage

//--- verif/tb.sv
`timescale 1ns/100ps
module tb;
   // stimulus
   logic core_clk = 1'b0, reset_n = 1'b0, iv = 1'b0, slp = 1'b0, dfile = 1'b0;
   logic rdq = 1'b0, pld = 1'b0, wen = 1'b0, tsp = 1'b0;
   csb_pkg::csb_op_t iop = csb_pkg::CSB_OP_NONE;
   logic [7:0] wv = 8'h00, sv = 8'h00, sm, lo;
   logic [6:0] fld = 7'h00, rfl = 7'h00;
   // observed
   logic [7:0] res, rdd, st, opt;
   logic [8:0] daddr, rda, sum;
   logic [12:0] pc;
   logic wwr, ewr, rdl, tick, wto, sub, dc;
   logic [31:0] rnd = 32'h0ff0736d;
   int miscompares = 0, check_count = 0, ticks = 0, n;
   csb_pkg::csb_op_t ops [4] = '{csb_pkg::CSB_OP_ADD_FILE, csb_pkg::CSB_OP_ADD_LIT,
                                 csb_pkg::CSB_OP_SUB_FILE, csb_pkg::CSB_OP_SUB_LIT};
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) ticks <= ticks + (tick === 1'b1);
   csb_core csb_core_i
   (
      .core_clk(core_clk), .reset_n(reset_n), .instr_valid(iv), .instr_op(iop),
      .instr_sleep(slp), .work_val(wv), .src_val(sv), .file_field(fld), .bit_sel(3'h0),
      .dest_is_file(dfile), .result_r(res), .work_wr_r(wwr), .ext_wr_r(ewr),
      .data_addr_r(daddr), .rd_req(rdq), .rd_field(rfl), .rd_data_r(rdd),
      .rd_local_r(rdl), .rd_addr_r(rda), .pc_step(1'b0), .pc_load(pld),
      .pc_load_low(lo), .pc_r(pc), .wdog_enable(wen), .wdog_period_sel(4'h0),
      .timer_src_pulse(tsp), .timer_tick_r(tick), .wdog_timeout_r(wto),
      .status_out_r(st), .option_out_r(opt)
   );
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nx(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(string nm, logic [12:0] e, logic [12:0] g);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one instruction; inputs change at the falling edge only
   task automatic op(csb_pkg::csb_op_t o, logic [7:0] w, logic [7:0] s, logic [6:0] f,
                     logic d);
      iop = o;
      wv = w;
      sv = s;
      fld = f;
      dfile = d;
      iv = 1'b1;
      // valid stays up so back-to-back calls never touch it twice in one step
      @(negedge core_clk);
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // the longest leg is one full watchdog period
   initial
   begin
      #(40 * 40000);
      miscompares++;
      end_of_test;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      lo = 8'h34;
      repeat (2) @(negedge core_clk);
      reset_n = 1'b1;
      sm = 8'h18;
      chk("status", sm, st);
      chk("option", 8'hff, opt);
      for (int i = 0; i < 24; i++)
      begin
         rnd = nx(rnd);
         sub = (i % 4) > 1;
         // subtraction adds the inverted work value plus one
         sum = {1'b0, rnd[15:8]} + {1'b0, sub ? ~rnd[7:0] : rnd[7:0]} + {8'h00, sub};
         dc = ({1'b0, rnd[11:8]} + {1'b0, sub ? ~rnd[3:0] : rnd[3:0]} + {4'h0, sub}) > 5'd15;
         op(ops[i % 4], rnd[7:0], rnd[15:8], 7'h20, 1'b0);
         sm[2:0] = {sum[7:0] == 8'h00, dc, sum[8]};
         chk("result", sum[7:0], res);
         chk("status", sm, st);
         chk("work write", 1'b1, wwr);
      end
      for (int i = 0; i < 4; i++)
      begin
         rnd = nx(rnd);
         op(i[0] ? csb_pkg::CSB_OP_ROT_RIGHT : csb_pkg::CSB_OP_ROT_LEFT, 8'h00, rnd[7:0],
            7'h20, 1'b0);
         chk("rotate", i[0] ? {sm[0], rnd[7:1]} : {rnd[6:0], sm[0]}, res);
         sm[0] = i[0] ? rnd[0] : rnd[7];
         chk("status", sm, st);
      end
      slp = 1'b1;
      op(csb_pkg::CSB_OP_NONE, 8'h00, 8'h00, 7'h20, 1'b0);
      slp = 1'b0;
      sm[4:3] = 2'b10;
      chk("status", sm, st);
      op(csb_pkg::CSB_OP_MOVE, 8'hff, 8'h00, 7'h03, 1'b1);
      sm = {3'b111, sm[4:3], 3'b111};
      chk("status", sm, st);
      op(csb_pkg::CSB_OP_ADD_FILE, 8'h01, 8'hff, 7'h20, 1'b1);
      sm[2:0] = 3'b111;
      chk("addr", 9'h1a0, daddr);
      chk("ext write", 1'b1, ewr);
      chk("status", sm, st);
      op(csb_pkg::CSB_OP_MOVE, 8'h15, 8'h00, 7'h0a, 1'b1);
      rdq = 1'b1;
      rfl = 7'h0a;
      pld = 1'b1;
      op(csb_pkg::CSB_OP_NONE, 8'h00, 8'h00, 7'h20, 1'b0);
      rdq = 1'b0;
      pld = 1'b0;
      chk("pc", 13'h1534, pc);
      chk("read", 8'h15, rdd);
      chk("read addr", 9'h00a, rda);
      chk("read local", 1'b1, rdl);
      op(csb_pkg::CSB_OP_CLEAR, 8'h00, 8'h00, 7'h03, 1'b1);
      sm = {3'b000, sm[4:3], 1'b1, sm[1:0]};
      chk("status", sm, st);
      op(csb_pkg::CSB_OP_ADD_FILE, 8'h01, 8'h01, 7'h20, 1'b1);
      chk("addr", 9'h020, daddr);
      op(csb_pkg::CSB_OP_MOVE, 8'h80, 8'h00, 7'h03, 1'b1);
      op(csb_pkg::CSB_OP_MOVE, 8'h40, 8'h00, 7'h04, 1'b1);
      op(csb_pkg::CSB_OP_MOVE, 8'h55, 8'h00, 7'h00, 1'b1);
      chk("indirect addr", 9'h140, daddr);
      chk("ext write", 1'b1, ewr);
      op(csb_pkg::CSB_OP_KICK, 8'h00, 8'h00, 7'h20, 1'b0);
      sm = {3'b100, 2'b11, 3'b000};
      chk("status", sm, st);
      // bank three again, so the option register is reached directly
      op(csb_pkg::CSB_OP_MOVE, 8'h60, 8'h00, 7'h03, 1'b1);
      sm = 8'h78;
      chk("status", sm, st);
      op(csb_pkg::CSB_OP_MOVE, 8'h00, 8'h00, 7'h0b, 1'b1);
      chk("shared addr", 9'h00b, daddr);
      chk("ext write", 1'b1, ewr);
      op(csb_pkg::CSB_OP_BIT_SET, 8'h00, sm, 7'h03, 1'b1);
      sm[0] = 1'b1;
      chk("status", sm, st);
      op(csb_pkg::CSB_OP_AND, 8'h0f, 8'hf0, 7'h20, 1'b0);
      sm[2] = 1'b1;
      chk("status", sm, st);
      chk("work write", 1'b1, wwr);
      // scaler stays still while owned by a disabled watchdog, so counts stay aligned
      for (int r = -1; r < 4; r++)
      begin
         if (r >= 0)
            op(csb_pkg::CSB_OP_MOVE, r[7:0], 8'h00, 7'h01, 1'b1);
         iv = 1'b0;
         @(negedge core_clk);
         chk("option", r < 0 ? 8'hff : r[7:0], opt);
         n = ticks;
         // ratio two also sees back-to-back source pulses
         repeat (128)
         begin
            tsp = (r == 0) || !tsp;
            @(negedge core_clk);
         end
         tsp = 1'b0;
         @(negedge core_clk);
         chk("ticks", r == 0 ? 64 : 64 >> (r + 1), ticks - n);
      end
      wen = 1'b1;
      n = 0;
      while (wto !== 1'b1 && n < 17000)
      begin
         @(negedge core_clk);
         n++;
      end
      chk("wdog span", 1'b1, n >= 16383 && n <= 16386);
      chk("expiry flag", 1'b0, st[4]);
      end_of_test;
   end
endmodule
